// [shared/sec_tx_pkg.sv]
package sec_tx_pkg;

  localparam int unsigned NUM_CH = 8;
  localparam int unsigned SAMPLE_W = 32;
  localparam int unsigned ADDR_W = 10;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_FRAMING = 8'h1A;
  localparam logic [7:0] IDX_MSB_DELAY = 8'h1C;
  localparam logic [7:0] IDX_PIN_PICK = 8'h1D;
  localparam logic [7:0] IDX_STATUS = 8'h30;

  // Field positions
  localparam int unsigned FRAMING_LSB = 6;
  localparam int unsigned SLOT_WIDTH_LSB = 4;
  localparam int unsigned DELAY_W = 5;
  localparam int unsigned STAT_PENDING_BIT = 0;
  localparam int unsigned STAT_DIRTY_BIT = 1;
  localparam int unsigned STAT_FRAMES_LSB = 8;

  // Reset values
  localparam logic [1:0] FRAMING_RESET = 2'h0;
  localparam logic [1:0] SLOT_WIDTH_RESET = 2'h3;
  localparam logic [4:0] MSB_DELAY_RESET = 5'h00;
  localparam logic [2:0] DELAY_RSVD_VALUE = 3'h0;
  localparam logic [7:0] PIN_PICK_RESET = 8'h00;

  typedef enum logic [1:0] {
    FRAMING_TDM = 2'h0,
    FRAMING_I2S = 2'h1,
    FRAMING_LJ = 2'h2,
    FRAMING_RSVD = 2'h3
  } framing_t;

  typedef enum logic [1:0] {
    SLOT_16 = 2'h0,
    SLOT_20 = 2'h1,
    SLOT_24 = 2'h2,
    SLOT_32 = 2'h3
  } slot_width_t;

  // Lowest bit index of an MSB-aligned 32-bit sample for each slot width
  localparam logic [4:0] LAST_POS_16 = 5'h10;
  localparam logic [4:0] LAST_POS_20 = 5'h0C;
  localparam logic [4:0] LAST_POS_24 = 5'h08;
  localparam logic [4:0] LAST_POS_32 = 5'h00;
  localparam logic [4:0] MSB_POS = 5'h1F;

  // Standard MSB lead after the frame edge, in bit clocks
  localparam logic [5:0] STD_LEAD_I2S = 6'h01;
  localparam logic [5:0] STD_LEAD_OTHER = 6'h00;

  typedef enum logic [2:0] {
    LINK_IDLE = 3'b001,
    LINK_WAIT = 3'b010,
    LINK_SHIFT = 3'b100
  } link_state_t;

  typedef logic [NUM_CH-1:0][SAMPLE_W-1:0] frame_samples_t;

  typedef struct packed {
    framing_t framing;
    slot_width_t slot_width;
    logic [4:0] msb_delay;
    logic [NUM_CH-1:0] pin_pick;
  } tx_cfg_t;

  typedef struct packed {
    tx_cfg_t cfg;
    frame_samples_t samples;
  } tx_bundle_t;

endpackage : sec_tx_pkg

// [src/bit_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module bit_sync (
  input wire logic clk_i,
  input wire logic d_i,
  output logic q_o
);

  logic meta;
  logic stage2;
  logic stage3;

  // Three stages, no reset so it also carries reset itself
  // Output moves only once the last two agree, so one late settle cannot glitch through
  always_ff @(posedge clk_i) begin
    meta <= d_i;
    stage2 <= meta;
    stage3 <= stage2;
    if (stage2 == stage3) begin
      q_o <= stage3;
    end
  end

endmodule : bit_sync
`default_nettype wire

// [src/tx_pin_serializer.sv]
`timescale 1ns/1ps
`default_nettype none
module tx_pin_serializer #(
  parameter logic PIN_ID = 1'b0
) (
  input wire sec_tx_pkg::frame_samples_t samples_i,
  input wire logic [sec_tx_pkg::NUM_CH-1:0] pin_pick_i,
  input wire logic [4:0] rank_i,
  input wire logic [4:0] bit_pos_i,
  output logic bit_o
);

  always_comb begin
    logic [4:0] rank;
    logic found;
    rank = 5'h00;
    found = 1'b0;
    bit_o = 1'b0;
    for (int i = 0; i < sec_tx_pkg::NUM_CH; i++) begin
      // Channel i+1 belongs to this pin when its pick bit equals PIN_ID
      if (pin_pick_i[i] == PIN_ID) begin
        if (!found && rank == rank_i) begin
          bit_o = samples_i[i][bit_pos_i];
          found = 1'b1;
        end
        rank = rank + 5'h01;
      end
    end
  end

endmodule : tx_pin_serializer
`default_nettype wire

// [src/secondary_tx_core.sv]
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module secondary_tx_core (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [sec_tx_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire sec_tx_pkg::frame_samples_t sample_i,
  input wire logic sample_valid_i,
  output logic sample_ready_o,
  input wire logic bclk_i,
  input wire logic fsync_i,
  output logic serial_out_pin_o,
  output logic second_serial_out_pin_o
);

  // ---------------- Register side, clk_i domain ----------------
  sec_tx_pkg::framing_t secondary_framing_code;
  sec_tx_pkg::slot_width_t secondary_slot_width;
  logic [sec_tx_pkg::DELAY_W-1:0] secondary_tx_msb_delay;
  logic [sec_tx_pkg::NUM_CH-1:0] secondary_tx_channel_pin_select;

  logic bus_ack;
  logic [31:0] readdata;
  logic cfg_dirty;
  logic req_tgl;
  logic ack_sync;
  logic frame_sync;
  logic frame_sync_d;
  logic [7:0] frame_count;
  sec_tx_pkg::tx_bundle_t bundle;

  wire bus_req = avs_read_i | avs_write_i;
  wire wr_fire = avs_write_i & bus_ack & avs_byteenable_i[0];
  wire hit_framing = avs_address_i == {sec_tx_pkg::IDX_FRAMING, 2'h0};
  wire hit_delay = avs_address_i == {sec_tx_pkg::IDX_MSB_DELAY, 2'h0};
  wire hit_pick = avs_address_i == {sec_tx_pkg::IDX_PIN_PICK, 2'h0};
  wire hit_status = avs_address_i == {sec_tx_pkg::IDX_STATUS, 2'h0};
  wire cfg_write = wr_fire & (hit_framing | hit_delay | hit_pick);

  // A bundle is in flight until the link side echoes the toggle back
  wire pending = req_tgl != ack_sync;
  wire launch = !pending && (cfg_dirty || sample_valid_i);
  wire frame_tick = frame_sync ^ frame_sync_d;

  wire [31:0] rd_framing = {24'h000000, secondary_framing_code, secondary_slot_width, 4'h0};
  wire [31:0] rd_delay = {24'h000000, sec_tx_pkg::DELAY_RSVD_VALUE, secondary_tx_msb_delay};
  wire [31:0] rd_pick = {24'h000000, secondary_tx_channel_pin_select};
  wire [31:0] rd_status = {16'h0000, frame_count, 6'h00, cfg_dirty, pending};
  wire [31:0] rd_word = hit_framing ? rd_framing :
                        hit_delay ? rd_delay :
                        hit_pick ? rd_pick :
                        hit_status ? rd_status : 32'h00000000;

  // Clear bit keeps the channel on the first pin, set bit moves it to the second
  wire sec_out_ch1_pin_pick = secondary_tx_channel_pin_select[0];
  wire sec_out_ch2_pin_pick = secondary_tx_channel_pin_select[1];
  wire sec_out_ch3_pin_pick = secondary_tx_channel_pin_select[2];
  wire sec_out_ch4_pin_pick = secondary_tx_channel_pin_select[3];
  wire sec_out_ch5_pin_pick = secondary_tx_channel_pin_select[4];
  wire sec_out_ch6_pin_pick = secondary_tx_channel_pin_select[5];
  wire sec_out_ch7_pin_pick = secondary_tx_channel_pin_select[6];
  wire sec_out_ch8_pin_pick = secondary_tx_channel_pin_select[7];

  wire sec_tx_pkg::tx_cfg_t staged_cfg = '{
    framing: secondary_framing_code,
    slot_width: secondary_slot_width,
    msb_delay: secondary_tx_msb_delay,
    pin_pick: {sec_out_ch8_pin_pick, sec_out_ch7_pin_pick, sec_out_ch6_pin_pick, sec_out_ch5_pin_pick,
               sec_out_ch4_pin_pick, sec_out_ch3_pin_pick, sec_out_ch2_pin_pick, sec_out_ch1_pin_pick}
  };

  assign avs_waitrequest_o = bus_req & ~bus_ack;
  assign avs_readdata_o = readdata;
  // Producer stalls while a bundle is still crossing
  assign sample_ready_o = ~pending;

  // One wait state: answer at the second edge of every request
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      bus_ack <= 1'b0;
      readdata <= 32'h00000000;
    end else begin
      bus_ack <= bus_req & ~bus_ack;
      if (avs_read_i && !bus_ack) begin
        readdata <= rd_word;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      secondary_framing_code <= sec_tx_pkg::framing_t'(sec_tx_pkg::FRAMING_RESET);
      secondary_slot_width <= sec_tx_pkg::slot_width_t'(sec_tx_pkg::SLOT_WIDTH_RESET);
    end else if (wr_fire && hit_framing) begin
      secondary_framing_code <= sec_tx_pkg::framing_t'(avs_writedata_i[sec_tx_pkg::FRAMING_LSB +: 2]);
      secondary_slot_width <= sec_tx_pkg::slot_width_t'(avs_writedata_i[sec_tx_pkg::SLOT_WIDTH_LSB +: 2]);
    end
  end

  // Only the low five bits are stored; the upper three cannot hold anything
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      secondary_tx_msb_delay <= sec_tx_pkg::MSB_DELAY_RESET;
    end else if (wr_fire && hit_delay) begin
      secondary_tx_msb_delay <= avs_writedata_i[sec_tx_pkg::DELAY_W-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      secondary_tx_channel_pin_select <= sec_tx_pkg::PIN_PICK_RESET;
    end else if (wr_fire && hit_pick) begin
      secondary_tx_channel_pin_select <= avs_writedata_i[sec_tx_pkg::NUM_CH-1:0];
    end
  end

  // A write in the launch cycle keeps dirty set, so it is resent later
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      cfg_dirty <= 1'b1;
      req_tgl <= 1'b0;
      bundle <= '0;
    end else begin
      cfg_dirty <= cfg_write | (cfg_dirty & ~launch);
      if (launch) begin
        req_tgl <= ~req_tgl;
        bundle.cfg <= staged_cfg;
        if (sample_valid_i) begin
          bundle.samples <= sample_i;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      frame_sync_d <= 1'b0;
      frame_count <= 8'h00;
    end else begin
      frame_sync_d <= frame_sync;
      if (frame_tick) begin
        frame_count <= frame_count + 8'h01;
      end
    end
  end

  // ---------------- Link side, bclk_i domain ----------------
  logic link_rst_n;
  logic req_sync;
  logic ack_tgl;
  logic frame_tgl;
  logic fsync_d;
  logic right_half;
  logic [5:0] wait_cnt;
  logic [4:0] bit_pos;
  logic [4:0] slot_rank;
  logic [1:0] sd_q;
  logic [1:0] ser_bit;
  sec_tx_pkg::link_state_t state;
  sec_tx_pkg::link_state_t next_state;
  sec_tx_pkg::tx_bundle_t act;

  bit_sync u_rst_sync (
    .clk_i(bclk_i),
    .d_i(resetn_i),
    .q_o(link_rst_n)
  );

  bit_sync u_req_sync (
    .clk_i(bclk_i),
    .d_i(req_tgl),
    .q_o(req_sync)
  );

  bit_sync u_ack_sync (
    .clk_i(clk_i),
    .d_i(ack_tgl),
    .q_o(ack_sync)
  );

  bit_sync u_frame_sync (
    .clk_i(clk_i),
    .d_i(frame_tgl),
    .q_o(frame_sync)
  );

  wire fs_rise = fsync_i & ~fsync_d;
  wire fs_fall = ~fsync_i & fsync_d;
  // Reserved code keeps framing like TDM so a later bundle can still be taken;
  // its pins stay at zero meanwhile
  wire is_rsvd = act.cfg.framing == sec_tx_pkg::FRAMING_RSVD;
  wire is_tdm = (act.cfg.framing == sec_tx_pkg::FRAMING_TDM) | is_rsvd;
  wire is_i2s = act.cfg.framing == sec_tx_pkg::FRAMING_I2S;
  wire is_lj = act.cfg.framing == sec_tx_pkg::FRAMING_LJ;
  wire stereo = is_i2s | is_lj;

  // I2S left half opens on the falling frame sync, LJ and TDM on the rising one
  wire left_start = ((is_tdm | is_lj) & fs_rise) | (is_i2s & fs_fall);
  wire right_start = (is_i2s & fs_rise) | (is_lj & fs_fall);
  wire take = left_start & (req_sync != ack_tgl);

  // Settings of the frame now starting: a fresh bundle applies at once
  wire sec_tx_pkg::tx_cfg_t cfg_eff = take ? bundle.cfg : act.cfg;
  wire [5:0] std_lead = (cfg_eff.framing == sec_tx_pkg::FRAMING_I2S) ?
                        sec_tx_pkg::STD_LEAD_I2S : sec_tx_pkg::STD_LEAD_OTHER;
  // Same lead for left and right halves and for every frame
  wire [5:0] lead = std_lead + {1'b0, cfg_eff.msb_delay};

  wire [4:0] last_pos = (act.cfg.slot_width == sec_tx_pkg::SLOT_16) ? sec_tx_pkg::LAST_POS_16 :
                        (act.cfg.slot_width == sec_tx_pkg::SLOT_20) ? sec_tx_pkg::LAST_POS_20 :
                        (act.cfg.slot_width == sec_tx_pkg::SLOT_24) ? sec_tx_pkg::LAST_POS_24 :
                        sec_tx_pkg::LAST_POS_32;
  wire slot_done = bit_pos == last_pos;
  wire frame_start = left_start | right_start;
  wire send_zero = !link_rst_n || state != sec_tx_pkg::LINK_SHIFT || is_rsvd;

  // Stereo sends one slot per half; TDM walks the slots in order
  wire [4:0] rank_sel = stereo ? ((slot_rank == 5'h00) ? {4'h0, right_half} : 5'h1F) : slot_rank;

  always_comb begin
    next_state = state;
    unique case (state)
      sec_tx_pkg::LINK_IDLE: begin
        next_state = sec_tx_pkg::LINK_IDLE;
      end
      sec_tx_pkg::LINK_WAIT: begin
        if (wait_cnt == 6'h01) begin
          next_state = sec_tx_pkg::LINK_SHIFT;
        end
      end
      sec_tx_pkg::LINK_SHIFT: begin
        next_state = sec_tx_pkg::LINK_SHIFT;
      end
      default: begin
        next_state = sec_tx_pkg::LINK_IDLE;
      end
    endcase
    if (frame_start) begin
      next_state = (lead == 6'h00) ? sec_tx_pkg::LINK_SHIFT : sec_tx_pkg::LINK_WAIT;
    end
  end

  always_ff @(posedge bclk_i) begin
    if (!link_rst_n) begin
      fsync_d <= 1'b0;
      state <= sec_tx_pkg::LINK_IDLE;
    end else begin
      fsync_d <= fsync_i;
      state <= next_state;
    end
  end

  // Bundle changes hands only at a left or TDM frame start
  always_ff @(posedge bclk_i) begin
    if (!link_rst_n) begin
      ack_tgl <= 1'b0;
      frame_tgl <= 1'b0;
      act <= '0;
    end else begin
      if (take) begin
        act <= bundle;
        ack_tgl <= ~ack_tgl;
      end
      if (left_start) begin
        frame_tgl <= ~frame_tgl;
      end
    end
  end

  always_ff @(posedge bclk_i) begin
    if (!link_rst_n) begin
      wait_cnt <= 6'h00;
      right_half <= 1'b0;
    end else if (frame_start) begin
      wait_cnt <= lead;
      right_half <= right_start;
    end else if (state == sec_tx_pkg::LINK_WAIT) begin
      wait_cnt <= wait_cnt - 6'h01;
    end
  end

  // Later slots follow back to back, so they keep the same shift
  always_ff @(posedge bclk_i) begin
    if (!link_rst_n || frame_start) begin
      bit_pos <= sec_tx_pkg::MSB_POS;
      slot_rank <= 5'h00;
    end else if (state == sec_tx_pkg::LINK_SHIFT) begin
      bit_pos <= slot_done ? sec_tx_pkg::MSB_POS : bit_pos - 5'h01;
      if (slot_done && slot_rank != 5'h1F) begin
        slot_rank <= slot_rank + 5'h01;
      end
    end
  end

  genvar p;
  generate
    for (p = 0; p < 2; p++) begin : g_pin
      // Both pins share one timing chain, hence one delay
      tx_pin_serializer #(
        .PIN_ID(1'(p))
      ) u_ser (
        .samples_i(act.samples),
        .pin_pick_i(act.cfg.pin_pick),
        .rank_i(rank_sel),
        .bit_pos_i(bit_pos),
        .bit_o(ser_bit[p])
      );
    end
  endgenerate

  // Unused cycles and the reserved framing code send zero
  always_ff @(posedge bclk_i) begin
    if (send_zero) begin
      sd_q <= 2'h0;
    end else begin
      sd_q <= ser_bit;
    end
  end

  assign serial_out_pin_o = sd_q[0];
  assign second_serial_out_pin_o = sd_q[1];

endmodule : secondary_tx_core
`default_nettype wire

// [dv/sec_tx_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module sec_tx_asserts (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [sec_tx_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic sample_valid_i,
  input wire logic sample_ready_o
);
  logic [7:0] pick;
  logic [4:0] delay;
  wire req = avs_read_i || avs_write_i;
  wire wr_done = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
  wire rd_done = avs_read_i && !avs_waitrequest_o;
  wire at_pick = avs_address_i == {sec_tx_pkg::IDX_PIN_PICK, 2'h0};
  wire at_delay = avs_address_i == {sec_tx_pkg::IDX_MSB_DELAY, 2'h0};
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      pick <= 8'h00;
      delay <= 5'h00;
    end else if (wr_done && at_pick) begin
      pick <= avs_writedata_i[7:0];
    end else if (wr_done && at_delay) begin
      delay <= avs_writedata_i[4:0];
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  sequence req_wait_s;
    req && avs_waitrequest_o;
  endsequence
  sequence req_done_s;
    req && !avs_waitrequest_o;
  endsequence
  wait_state_a: assert property (req_wait_s |=> !avs_waitrequest_o)
    else $error("no answer after one wait state");
  wait_rearm_a: assert property (req_done_s |=> avs_waitrequest_o == req)
    else $error("waitrequest not rearmed");
  idle_wait_a: assert property (!req |-> !avs_waitrequest_o)
    else $error("waitrequest without request");
  delay_read_a: assert property (rd_done && at_delay |-> avs_readdata_o == {27'h0, delay})
    else $error("delay register readback wrong");
  pick_read_a: assert property (rd_done && at_pick |-> avs_readdata_o == {24'h0, pick})
    else $error("pin pick readback wrong");
  upper_zero_a: assert property (rd_done |-> avs_readdata_o[31:16] == 16'h0000)
    else $error("upper read bits set");
  rdata_hold_a: assert property (!avs_read_i |=> $stable(avs_readdata_o))
    else $error("read data moved without read");
  ready_drop_a: assert property (sample_valid_i && sample_ready_o |=> !sample_ready_o)
    else $error("ready stayed high after take");
endmodule : sec_tx_asserts
bind secondary_tx_core sec_tx_asserts u_sec_tx_asserts (.clk_i(clk_i), .resetn_i(resetn_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .sample_valid_i(sample_valid_i), .sample_ready_o(sample_ready_o));
`default_nettype wire

// [dv/serial_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module serial_host_model (
  input wire logic [1:0] mode_i,
  input wire logic pin0_i,
  input wire logic pin1_i,
  output logic bclk_o,
  output logic fsync_o,
  output logic [319:0] frame0_o,
  output logic [319:0] frame1_o,
  output logic [31:0] frames_o
);
  localparam int LEN = 320;
  int cnt = 0;
  logic [319:0] cap0;
  logic [319:0] cap1;
  wire early = ((cnt + 1) % LEN) < LEN / 2;
  initial begin
    bclk_o = 1'h0;
    fsync_o = 1'h0;
    frames_o = 32'h0;
  end
  // Bit clock runs free, it must also tick through reset
  always #32 bclk_o = ~bclk_o;
  // TDM pulse at frame start, LJ high and I2S low in the left half
  always @(posedge bclk_o) begin
    cnt <= (cnt + 1) % LEN;
    fsync_o <= mode_i == 2'h0 ? cnt == LEN - 1 : (mode_i == 2'h1) ^ early;
  end
  // Sampled half a bit after the pins move
  always @(negedge bclk_o) begin
    cap0[(cnt + LEN - 2) % LEN] = pin0_i;
    cap1[(cnt + LEN - 2) % LEN] = pin1_i;
    if (cnt == 1) begin
      frame0_o <= cap0;
      frame1_o <= cap1;
      frames_o <= frames_o + 32'h1;
    end
  end
endmodule : serial_host_model
`default_nettype wire

// [dv/secondary_serial_tx_offset_routing_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fails++; \
  $display("CHECK FAILED at %0t: got %0h want %0h", $time, a, b); end end
module secondary_serial_tx_offset_routing_tb;
  logic clk_i = 1'h0;
  logic resetn_i = 1'h0;
  logic [9:0] avs_address_i = 10'h000;
  logic avs_read_i = 1'h0;
  logic avs_write_i = 1'h0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0] avs_byteenable_i = 4'hF;
  sec_tx_pkg::frame_samples_t sample_i = '0;
  logic sample_valid_i = 1'h0;
  logic [1:0] fr = 2'h0;
  logic [1:0] wc;
  logic [4:0] dl;
  logic [7:0] pk;
  logic [31:0] q;
  logic [4:0] dlt [5] = '{5'h01, 5'h02, 5'h1F, 5'h00, 5'h07};
  int seed = 39;
  int fails = 0;
  int tests_run = 0;
  wire logic [31:0] avs_readdata_o;
  wire logic avs_waitrequest_o, sample_ready_o, bclk, fsync, pin0, pin1;
  wire logic [319:0] got0, got1;
  wire logic [31:0] frames;
  always #25 clk_i = ~clk_i;
  secondary_tx_core DUT (.clk_i(clk_i), .resetn_i(resetn_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .sample_i(sample_i), .sample_valid_i(sample_valid_i),
    .sample_ready_o(sample_ready_o), .bclk_i(bclk), .fsync_i(fsync), .serial_out_pin_o(pin0),
    .second_serial_out_pin_o(pin1));
  serial_host_model host (.mode_i(fr), .pin0_i(pin0), .pin1_i(pin1), .bclk_o(bclk),
    .fsync_o(fsync), .frame0_o(got0), .frame1_o(got1), .frames_o(frames));
  function automatic logic [319:0] expect_frame(input logic pin);
    logic [319:0] v;
    int h, r, s, n, w, ld;
    v = '0;
    w = wc == 2'h3 ? 32 : 16 + 4 * wc;
    ld = dl + (fr == 2'h1);
    for (int i = 0; i < 320; i++) begin
      h = (fr != 2'h0 && i >= 160) ? 160 : 0;
      r = i - h - ld;
      s = fr == 2'h0 ? r / w : (r < w ? h / 160 : 99);
      n = 0;
      for (int c = 0; c < 8; c++) begin
        if (r >= 0 && fr != 2'h3 && pk[c] == pin) begin
          if (n == s) v[i] = sample_i[c][31 - r % w];
          n++;
        end
      end
    end
    return v;
  endfunction : expect_frame
  task automatic bus(input logic wr, input logic [9:0] a, input logic [7:0] d);
    @(posedge clk_i);
    avs_address_i <= a;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    avs_writedata_i <= {24'h000000, d};
    // Only the watchdog ends a hung wait
    do begin
      @(posedge clk_i);
    end while (avs_waitrequest_o !== 1'h0);
    q = avs_readdata_o;
    avs_write_i <= 1'h0;
    avs_read_i <= 1'h0;
  endtask : bus
  task automatic wait_ready;
    while (sample_ready_o !== 1'h1) @(posedge clk_i);
  endtask : wait_ready
  task automatic wait_frames(input int k);
    int f;
    f = frames;
    while (frames < f + k) @(posedge clk_i);
  endtask : wait_frames
  task automatic run_case;
    bus(1'h1, 10'h068, {fr, wc, 4'h0});
    bus(1'h1, 10'h070, {3'h0, dl});
    bus(1'h1, 10'h074, pk);
    wait_ready();
    for (int c = 0; c < 8; c++) sample_i[c] <= $random(seed);
    sample_valid_i <= 1'h1;
    // Valid holds until the edge at which ready is seen high
    do begin
      @(posedge clk_i);
    end while (sample_ready_o !== 1'h1);
    sample_valid_i <= 1'h0;
    @(posedge clk_i);
    wait_ready();
    wait_frames(2);
    `CHK(got0, expect_frame(1'h0))
    `CHK(got1, expect_frame(1'h1))
    wait_frames(1);
    `CHK({got0, got1}, {expect_frame(1'h0), expect_frame(1'h1)})
    bus(1'h0, 10'h0C0, 8'h00);
    `CHK(q[1:0], 2'h0)
  endtask : run_case
  task automatic give_verdict;
    $display("fails=%0d tests_run=%0d", fails, tests_run);
    if (fails == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : give_verdict
  initial begin
    #(60000 * 50);
    fails++;
    give_verdict();
  end
  initial begin
    repeat (5) @(posedge clk_i);
    resetn_i <= 1'h1;
    bus(1'h0, 10'h068, 8'h00);
    `CHK(q, 32'h00000030)
    bus(1'h0, 10'h070, 8'h00);
    `CHK(q, 32'h00000000)
    bus(1'h1, 10'h070, 8'h1F);
    bus(1'h0, 10'h070, 8'h00);
    `CHK(q, 32'h0000001F)
    avs_byteenable_i <= 4'hE;
    bus(1'h1, 10'h074, 8'hFF);
    avs_byteenable_i <= 4'hF;
    bus(1'h0, 10'h074, 8'h00);
    `CHK(q, 32'h00000000)
    bus(1'h0, 10'h3FC, 8'h00);
    `CHK(q, 32'h00000000)
    for (int k = 0; k < 10; k++) begin
      if (k < 5) begin
        fr = k < 3 ? 2'h0 : 2'(k - 2);
        wc = 2'(k);
        dl = dlt[k];
        pk = k == 0 ? 8'h00 : (k == 1 ? 8'hFF : 8'($random(seed)));
      end else begin
        fr = k == 5 ? 2'h3 : 2'({$random(seed)} % 3);
        wc = 2'($random(seed));
        dl = 5'($random(seed));
        pk = 8'($random(seed));
      end
      run_case();
    end
    give_verdict();
  end
endmodule : secondary_serial_tx_offset_routing_tb
`default_nettype wire
